// File: design/pic_pkg.sv
// pic_pkg: register map, field layout and reset values of the prioritized interrupt controller
// assumes apb with 32-bit data; offsets are word indices, byte address is index * 4
package pic_pkg;
  localparam int          PIC_NUM_SRC       = 28;
  localparam int          PIC_BANK_W        = 16;
  localparam int          PIC_VEC_W         = 5;
  localparam int          PIC_CNT_W         = 3;
  localparam int          PIC_ADDR_W        = 18;
  // printed word indices
  localparam logic [15:0] PIC_IDX_EN_LOW0   = 16'hFC00;
  localparam logic [15:0] PIC_IDX_EN_LOW1   = 16'hFC01;
  localparam logic [15:0] PIC_IDX_EN_HIGH0  = 16'hFC02;
  localparam logic [15:0] PIC_IDX_EN_HIGH1  = 16'hFC03;
  localparam logic [15:0] PIC_IDX_PEND0     = 16'hFC04;
  localparam logic [15:0] PIC_IDX_PEND1     = 16'hFC05;
  localparam logic [15:0] PIC_IDX_VECTOR    = 16'hFC06;
  localparam logic [15:0] PIC_IDX_NEST      = 16'hFC07;
  localparam logic [15:0] PIC_IDX_PUSH      = 16'hFC08;
  localparam logic [15:0] PIC_IDX_POP       = 16'hFC09;
  localparam logic [15:0] PIC_IDX_IRQ_STAT  = 16'hFC0A;
  localparam logic [15:0] PIC_IDX_IRQ_MASK  = 16'hFC0B;
  // status/mask bit positions of the block's own interrupt line
  localparam int          PIC_EV_ISSUE      = 0;
  localparam int          PIC_EV_OVERFLOW   = 1;
  localparam int          PIC_EV_W          = 2;
  localparam logic [15:0] PIC_RST_BANK      = 16'h0000;
  localparam logic [4:0]  PIC_RST_VEC       = 5'h00;
  localparam logic [2:0]  PIC_RST_CNT       = 3'h0;
  typedef enum logic [1:0] {PIC_PRI_OFF, PIC_PRI_LOW, PIC_PRI_MED, PIC_PRI_HIGH} pic_pri_e;
endpackage

// File: design/pic_arbiter.sv
// pic_arbiter: picks the pending enabled source of highest priority
// assumes combinational use inside the controller's clock domain
`timescale 1ns/1ps
module pic_arbiter
  import pic_pkg::*;
#(
  parameter int N = PIC_NUM_SRC
) (
  input  wire logic [N-1:0]   pending,
  input  wire logic [N-1:0]   en_high,
  input  wire logic [N-1:0]   en_low,
  output logic                found,
  output logic [PIC_VEC_W-1:0] vector
);
  logic [1:0] best_pri;
  logic [1:0] pri;

  always_comb begin
    found    = 1'b0;
    vector   = PIC_RST_VEC;
    best_pri = 2'h0;
    pri      = 2'h0;
    // ascending scan with >= lets the higher vector win a tie
    for (int i = 0; i < N; i++) begin
      pri = {en_high[i], en_low[i]};
      if (pending[i] && pri != 2'h0 && pri >= best_pri) begin
        found    = 1'b1;
        best_pri = pri;
        vector   = PIC_VEC_W'(i);
      end
    end
  end
endmodule

// File: design/pic_ctrl.sv
// pic_ctrl: prioritized interrupt controller, apb register slave and vectored request to the core
// assumes sources are synchronous one-cycle-or-longer request levels on core_clk
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - enable bits for sources 0-15 in bank 0, 16-27 in bank 1.
// - source with both enable bits zero is disabled, never forwarded.
// - bit pair high,low: 01 low, 10 medium, 11 high priority.
// - pick highest priority pending source, also after unblocking.
// - any request sets its pending flag, enabled or not.
// - enabled pending source raises core request with its vector when counter zero.
// - pending flag clears automatically once its request is issued.
// - disabled sources keep flags set; reads return state unchanged.
// - pending write clears bits written one: old AND NOT written.
// - last issued vector held in a read-only register.
// - 3-bit nesting counter; forwarding only while it is zero.
// - counter increments on each issue and each push register write.
// - pop register write decrements counter if non-zero.
// - issue and push write in same cycle add two.
// - reading the nesting counter returns its value.
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int N = PIC_NUM_SRC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [PIC_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [N-1:0]          src_req,
  output logic                       core_irq,
  output logic      [PIC_VEC_W-1:0]  core_vector,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0]          en_low_ff;
  logic [31:0]          en_high_ff;
  logic [N-1:0]         pend_ff;
  logic [PIC_VEC_W-1:0] vec_ff;
  logic [PIC_CNT_W-1:0] cnt_ff;
  logic [PIC_EV_W-1:0]  stat_ff;
  logic [PIC_EV_W-1:0]  mask_ff;
  logic [31:0]          nxt_prdata;
  logic                 nxt_pslverr;

  function automatic logic [PIC_ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode: zero-wait-state slave, answer in the cycle after setup
  logic acc;
  logic wr;
  logic rd;
  logic known;

  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  function automatic logic hit(input logic [PIC_ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == byte_addr(idx));
  endfunction

  always_comb begin
    known = hit(paddr, PIC_IDX_EN_LOW0) || hit(paddr, PIC_IDX_EN_LOW1) ||
            hit(paddr, PIC_IDX_EN_HIGH0) || hit(paddr, PIC_IDX_EN_HIGH1) ||
            hit(paddr, PIC_IDX_PEND0) || hit(paddr, PIC_IDX_PEND1) ||
            hit(paddr, PIC_IDX_VECTOR) || hit(paddr, PIC_IDX_NEST) ||
            hit(paddr, PIC_IDX_PUSH) || hit(paddr, PIC_IDX_POP) ||
            hit(paddr, PIC_IDX_IRQ_STAT) || hit(paddr, PIC_IDX_IRQ_MASK);
  end

  // pready pulses in the access phase's first cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration and issue
  logic                 found;
  logic [PIC_VEC_W-1:0] pick;
  logic                 issue;

  pic_arbiter #(
    .N (N)
  ) u_arb (
    .pending (pend_ff),
    .en_high (en_high_ff[N-1:0]),
    .en_low  (en_low_ff[N-1:0]),
    .found   (found),
    .vector  (pick)
  );

  assign issue = found && (cnt_ff == PIC_RST_CNT);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_irq    <= 1'b0;
      core_vector <= PIC_RST_VEC;
    end else begin
      core_irq <= issue;
      if (issue) begin
        core_vector <= pick;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vec_ff <= PIC_RST_VEC;
    end else if (issue) begin
      vec_ff <= pick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // enable banks: low 16 bits of each bank 0 word, low 12 bits of each bank 1 word
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_low_ff  <= 32'h00000000;
      en_high_ff <= 32'h00000000;
    end else if (wr) begin
      if (hit(paddr, PIC_IDX_EN_LOW0)) en_low_ff[15:0] <= pwdata[15:0];
      if (hit(paddr, PIC_IDX_EN_LOW1)) en_low_ff[31:16] <= {4'h0, pwdata[11:0]};
      if (hit(paddr, PIC_IDX_EN_HIGH0)) en_high_ff[15:0] <= pwdata[15:0];
      if (hit(paddr, PIC_IDX_EN_HIGH1)) en_high_ff[31:16] <= {4'h0, pwdata[11:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags: requests win over software clear and over the issue clear
  logic [N-1:0] clr_mask;
  logic [N-1:0] issue_clr;
  logic [31:0]  wmask;

  always_comb begin
    wmask     = 32'h00000000;
    issue_clr = '0;
    if (wr && hit(paddr, PIC_IDX_PEND0)) wmask[15:0] = pwdata[15:0];
    if (wr && hit(paddr, PIC_IDX_PEND1)) wmask[31:16] = pwdata[15:0];
    if (issue) issue_clr[pick] = 1'b1;
    clr_mask = wmask[N-1:0] | issue_clr;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~clr_mask) | src_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nesting counter
  logic push;
  logic pop;

  assign push = wr && hit(paddr, PIC_IDX_PUSH);
  assign pop  = wr && hit(paddr, PIC_IDX_POP);

  // wraps modulo 8 on overflow; overflow is flagged instead of saturating
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= PIC_RST_CNT;
    end else if (wr && hit(paddr, PIC_IDX_NEST)) begin
      cnt_ff <= pwdata[PIC_CNT_W-1:0];
    end else begin
      cnt_ff <= cnt_ff + PIC_CNT_W'(issue) + PIC_CNT_W'(push)
                - PIC_CNT_W'(pop && cnt_ff != PIC_RST_CNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // own interrupt line: issue event and counter overflow
  logic [PIC_EV_W-1:0] ev;
  logic [PIC_EV_W-1:0] stat_clr;

  always_comb begin
    ev = '0;
    ev[PIC_EV_ISSUE]    = issue;
    ev[PIC_EV_OVERFLOW] = ({1'b0, cnt_ff} + {3'h0, issue} + {3'h0, push}) > 4'h7;
    stat_clr = (wr && hit(paddr, PIC_IDX_IRQ_STAT)) ? pwdata[PIC_EV_W-1:0] : '0;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | ev;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= '0;
    end else if (wr && hit(paddr, PIC_IDX_IRQ_MASK)) begin
      mask_ff <= pwdata[PIC_EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((stat_ff & ~stat_clr) | ev)) & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, registered at the edge that starts the access phase
  always_comb begin
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (hit(paddr, PIC_IDX_EN_LOW0)) nxt_prdata[15:0] = en_low_ff[15:0];
    if (hit(paddr, PIC_IDX_EN_LOW1)) nxt_prdata[15:0] = en_low_ff[31:16];
    if (hit(paddr, PIC_IDX_EN_HIGH0)) nxt_prdata[15:0] = en_high_ff[15:0];
    if (hit(paddr, PIC_IDX_EN_HIGH1)) nxt_prdata[15:0] = en_high_ff[31:16];
    if (hit(paddr, PIC_IDX_PEND0)) nxt_prdata[15:0] = pend_ff[15:0];
    if (hit(paddr, PIC_IDX_PEND1)) nxt_prdata[N-17:0] = pend_ff[N-1:16];
    if (hit(paddr, PIC_IDX_VECTOR)) nxt_prdata[PIC_VEC_W-1:0] = vec_ff;
    if (hit(paddr, PIC_IDX_NEST)) nxt_prdata[PIC_CNT_W-1:0] = cnt_ff;
    if (hit(paddr, PIC_IDX_IRQ_STAT)) nxt_prdata[PIC_EV_W-1:0] = stat_ff;
    if (hit(paddr, PIC_IDX_IRQ_MASK)) nxt_prdata[PIC_EV_W-1:0] = mask_ff;
    if (!known) nxt_pslverr = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h00000000 : nxt_prdata;
      pslverr <= nxt_pslverr;
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // rd kept for readability of the decode; reads have no side effects
  logic unused_rd;
  assign unused_rd = rd;

endmodule

// File: tb/pic_ctrl_chk.sv
// pic_ctrl_chk: assertions on the controller ports
// assumes a bind onto pic_ctrl; software moves the counter only by push and pop
`timescale 1ns/1ps
module pic_ctrl_chk
  import pic_pkg::*;
#(parameter int N = PIC_NUM_SRC) (
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire logic [PIC_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  core_irq,
  input wire logic [PIC_VEC_W-1:0]  core_vector
);
  logic       wr;
  logic       rd_cnt;
  logic [2:0] cnt_ff;
  logic [2:0] tru;
  assign wr     = psel && penable && pwrite && pready;
  assign rd_cnt = psel && penable && !pwrite && pready && paddr[17:2] == PIC_IDX_NEST;
  // a visible core_irq is already inside the design's count
  assign tru    = cnt_ff + {2'h0, core_irq};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cnt_ff <= 3'h0;
    else if (wr && paddr[17:2] == PIC_IDX_PUSH) cnt_ff <= tru + 3'h1;
    else if (wr && paddr[17:2] == PIC_IDX_POP && tru != 3'h0) cnt_ff <= tru - 3'h1;
    else cnt_ff <= tru;
  end
  ////////////////////////////////////////
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_gate; core_irq |-> $past(tru) == 3'h0; endproperty
  a_gate: assert property (p_gate) else $error("issue while counter set");
  property p_pulse; core_irq |=> !core_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("issue longer than a pulse");
  property p_push; wr && paddr[17:2] == PIC_IDX_PUSH |=> ##1 !core_irq [*2]; endproperty
  a_push: assert property (p_push) else $error("issue after push");
  property p_range; core_irq |-> core_vector <= 5'h1B; endproperty
  a_range: assert property (p_range) else $error("vector out of range");
  property p_hold; !core_irq |-> $stable(core_vector); endproperty
  a_hold: assert property (p_hold) else $error("vector moved");
  property p_read; rd_cnt |-> prdata == {29'h0, $past(tru)}; endproperty
  a_read: assert property (p_read) else $error("counter read wrong");
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("answer too long");
endmodule

// File: tb/pic_core_model.sv
// pic_core_model: core side, counts handler entries and keeps the last vector
// assumes core_irq is a one-cycle pulse on core_clk
`timescale 1ns/1ps
module pic_core_model
  import pic_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 core_irq,
  input  wire logic [PIC_VEC_W-1:0] core_vector,
  output logic      [7:0]           taken,
  output logic      [PIC_VEC_W-1:0] last_vec
);
  // a held level would count again each cycle, so only pulses are legal
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) {taken, last_vec} <= '0;
    else if (core_irq) {taken, last_vec} <= {taken + 8'h01, core_vector};
  end
endmodule

// File: tb/pic_ctrl_bench.sv
// pic_ctrl_bench: self-checking bench for the interrupt controller
// assumes pic_pkg, pic_ctrl, the core model and the checker compile first
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
module pic_ctrl_bench
  import pic_pkg::*;
;
  logic                   core_clk, rstn, psel, penable, pwrite, pready, pslverr, core_irq, irq, rerr;
  logic [PIC_ADDR_W-1:0]  paddr;
  logic [31:0]            pwdata, prdata, rdata;
  logic [31:0]            seed = 32'h53;
  logic [PIC_NUM_SRC-1:0] src_req, h, l, p, m;
  logic [PIC_VEC_W-1:0]   core_vector, last_vec, v;
  logic [7:0]             taken;
  int                     mismatches = 0, checked = 0, cnt = 0;
  pic_ctrl u_pic_ctrl (.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .core_irq(core_irq), .core_vector(core_vector), .irq(irq));
  pic_core_model u_pic_core_model (.core_clk(core_clk), .rstn(rstn), .core_irq(core_irq),
    .core_vector(core_vector), .taken(taken), .last_vec(last_vec));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // ties go upward so the last equal priority seen wins
  function automatic logic [4:0] pick(input logic [27:0] pv, input logic [27:0] hv, input logic [27:0] lv);
    logic [1:0] best;
    best = 2'h0;
    pick = 5'h00;
    for (int i = 0; i < 28; i++) begin
      if (pv[i] && {hv[i], lv[i]} != 2'h0 && {hv[i], lv[i]} >= best) begin
        best = {hv[i], lv[i]};
        pick = 5'(i);
      end
    end
  endfunction
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, i, 2'b00, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 16);
    if (n >= 16) mismatches++;
    {rdata, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    `CHK(rdata, e)
  endtask
  task automatic pulse(input logic [27:0] r);
    @(posedge core_clk);
    src_req <= r;
    @(posedge core_clk);
    src_req <= '0;
  endtask
  task automatic issued(input logic [4:0] ev);
    cnt++;
    repeat (64) if (taken !== 8'(cnt)) @(posedge core_clk);
    `CHK(taken, 8'(cnt))
    `CHK(last_vec, ev)
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, src_req} = '0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(PIC_IDX_EN_LOW0 + 16'(i), 32'h0);
    apb(1'b0, 16'hFC0C, 32'h0);
    `CHK(rerr, 1'b1)
    $display("reset test done");
    p = 28'(rnd());
    m = 28'(rnd());
    pulse(p);
    rd(PIC_IDX_PEND1, {20'h0, p[27:16]});
    apb(1'b1, PIC_IDX_PEND0, {16'h0, m[15:0]});
    rd(PIC_IDX_PEND0, {16'h0, p[15:0] & ~m[15:0]});
    `CHK(taken, 8'h00)
    apb(1'b1, PIC_IDX_PEND1, 32'hFFF);
    apb(1'b1, PIC_IDX_PEND0, 32'hFFFF);
    $display("polling test done");
    for (int k = 0; k < 5; k++) begin
      h = (k == 0) ? '1 : 28'(rnd());
      l = (k == 0) ? '1 : 28'(rnd());
      p = (k == 0) ? '1 : 28'(rnd());
      apb(1'b1, PIC_IDX_EN_LOW0, {16'h0, l[15:0]});
      apb(1'b1, PIC_IDX_EN_LOW1, {20'h0, l[27:16]});
      apb(1'b1, PIC_IDX_EN_HIGH0, {16'h0, h[15:0]});
      apb(1'b1, PIC_IDX_EN_HIGH1, {20'h0, h[27:16]});
      rd(PIC_IDX_EN_HIGH1, {20'h0, h[27:16]});
      apb(1'b1, PIC_IDX_PUSH, 32'h0);
      pulse(p);
      rd(PIC_IDX_NEST, 32'h1);
      while ((p & (h | l)) != '0) begin
        v = pick(p, h, l);
        apb(1'b1, PIC_IDX_POP, 32'h0);
        issued(v);
        p[v] = 1'b0;
        rd(PIC_IDX_VECTOR, {27'h0, v});
        rd(PIC_IDX_PEND0, {16'h0, p[15:0]});
      end
      repeat (2) apb(1'b1, PIC_IDX_POP, 32'h0);
      rd(PIC_IDX_NEST, 32'h0);
      apb(1'b1, PIC_IDX_PEND1, 32'hFFF);
      apb(1'b1, PIC_IDX_PEND0, 32'hFFFF);
    end
    $display("priority test done");
    apb(1'b1, PIC_IDX_EN_LOW0, 32'h8);
    apb(1'b1, PIC_IDX_IRQ_MASK, 32'h1);
    fork
      apb(1'b1, PIC_IDX_PUSH, 32'h0);
      pulse(28'h8);
    join
    issued(5'h03);
    rd(PIC_IDX_NEST, 32'h2);
    `CHK(irq, 1'b1)
    apb(1'b1, PIC_IDX_IRQ_MASK, 32'h0);
    rd(PIC_IDX_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    apb(1'b1, PIC_IDX_IRQ_STAT, 32'h1);
    apb(1'b1, PIC_IDX_IRQ_MASK, 32'h1);
    rd(PIC_IDX_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    repeat (2) apb(1'b1, PIC_IDX_POP, 32'h0);
    rd(PIC_IDX_NEST, 32'h0);
    $display("nesting test done");
    summarize();
  end
endmodule
bind pic_ctrl pic_ctrl_chk #(.N(N)) u_pic_ctrl_chk (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .core_irq(core_irq), .core_vector(core_vector));
